// ==== hw/rcg_pkg.sv ====
// constants and types shared by the reset and clock generator
// assumes a 32-bit apb register bus and a single block clock
package rcg_pkg;
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFFS = 12'h000;
    localparam logic [11:0] STAT_OFFS = 12'h004;
    localparam logic [11:0] CMD_OFFS  = 12'h008;

    // control register fields and reset value
    localparam int          CTRL_RATIO_LSB  = 0;
    localparam int          CTRL_DMA_HALF   = 2;
    localparam int          CTRL_COPRO_BLK  = 3;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // command register: write one for a fast processor reset
    localparam int          CMD_FAST_RESET  = 0;

    // status register fields
    localparam int          STAT_CPU_RST    = 0;
    localparam int          STAT_COPRO_RST  = 1;
    localparam int          STAT_BP_RST     = 2;
    localparam int          STAT_BCLK       = 3;
    localparam int          STAT_POR        = 4;

    // backplane divide ratio is base plus step times the selector
    localparam logic [3:0]  RATIO_BASE      = 4'h6;
    localparam logic [3:0]  RATIO_STEP      = 4'h2;

    // timer clock divides the colour burst reference by twelve
    localparam int          TIMER_DIV       = 12;
    localparam logic [3:0]  TIMER_HALF      = 4'(TIMER_DIV / 2);

    // coprocessor reset port
    localparam logic [15:0] COPRO_PORT      = 16'h00f1;

    // default length of a processor reset pulse in block cycles
    localparam int          RST_HOLD_CYCLES = 16;

    typedef struct packed {
        logic [1:0] ratioSel;
        logic       dmaHalf;
        logic       coproBlock;
    } rcg_cfg_t;

    // reset pulse sequencer, gray along idle, hold, align
    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_HOLD  = 2'b01,
        RST_ALIGN = 2'b11
    } rcg_rst_state_t;
endpackage

// ==== hw/rcg_reset_clock_gen.sv ====
// reset and clock generator: backplane, dma and timer clocks plus
// processor, coprocessor and backplane resets
// assumes ref_clk is the buffered double-rate processor clock and that
// io write strobes arrive on ref_clk; pins are synchronised here
//
// Behaviour
// RULE_01 - all state machines run straight from the double-rate processor clock
// RULE_02 - backplane clock is processor clock divided by 6, 8, 10 or 12, 50% duty
// RULE_03 - dma clock is the backplane clock or that clock halved, per setting
// RULE_04 - timer clock is the colour burst reference divided by twelve
// RULE_05 - power-on reset clears all logic and asserts all three reset outputs; the read data register and input synchronisers keep their values
// RULE_06 - processor reset is synchronous and released on the proper clock phase
// RULE_07 - keyboard reset request or fast reset bit also pulse the processor reset
// RULE_08 - coprocessor reset times like processor reset; only por or port write
// RULE_09 - port write coprocessor reset is enabled after por and can be blocked
// RULE_10 - backplane reset is synchronous to backplane clock and only from por
// RULE_11 - dividers restart from a known state so clocks start glitch-free
`timescale 1ns/100ps
module rcg_reset_clock_gen #(
    parameter int RST_HOLD = rcg_pkg::RST_HOLD_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        porIn,
    input  wire logic        keyboardResetRequest,
    input  wire logic        colorBurstReference,
    input  wire logic        ioWriteValid,
    input  wire logic [15:0] ioWriteAddr,
    output logic             backplaneClock,
    output logic             dmaClock,
    output logic             timerClock,
    output logic             processorResetOut,
    output logic             coprocessorResetOut,
    output logic             backplaneResetDrive
);
    logic [1:0]            porSync_q;
    logic [2:0]            kbdSync_q;
    logic [2:0]            refSync_q;
    logic                  porSync;
    logic                  kbdRise;
    logic                  refRise;
    rcg_pkg::rcg_cfg_t     cfg_q;
    logic                  setup;
    logic                  access;
    logic                  mapped;
    logic                  fastReq;
    logic [31:0]           prdata_q;
    logic                  phase_q;
    logic [3:0]            ratio_q;
    logic [3:0]            bclkCnt_q;
    logic                  bclkWrap;
    logic                  bclkRise;
    logic                  bclk_q;
    logic                  dmaDiv_q;
    logic                  dma_q;
    logic [3:0]            tmrCnt_q;
    logic                  tmr_q;
    logic                  copTrig;
    logic [1:0]            trig;
    logic [1:0]            rstOut_q;
    logic                  bpRst_q;
    rcg_pkg::rcg_rst_state_t st_q [2];
    rcg_pkg::rcg_rst_state_t st_d [2];
    logic [15:0]           holdCnt_q [2];

    // two-flop synchronisers, third flop only for edge detection
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            porSync_q <= 2'h3;
            kbdSync_q <= 3'h0;
            refSync_q <= 3'h0;
        end
        else
        begin
            porSync_q <= {porSync_q[0], porIn};
            kbdSync_q <= {kbdSync_q[1:0], keyboardResetRequest};
            refSync_q <= {refSync_q[1:0], colorBurstReference};
        end
    end
    assign porSync = porSync_q[1];
    assign kbdRise = kbdSync_q[1] & ~kbdSync_q[2];
    assign refRise = refSync_q[1] & ~refSync_q[2];

    // apb decode, zero wait states
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign mapped  = (paddr == rcg_pkg::CTRL_OFFS) || (paddr == rcg_pkg::STAT_OFFS)
                     || (paddr == rcg_pkg::CMD_OFFS);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;
    assign fastReq = access & pwrite & pstrb[0] & (paddr == rcg_pkg::CMD_OFFS)
                     & pwdata[rcg_pkg::CMD_FAST_RESET];

    // control register, cleared again by power-on reset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            cfg_q <= rcg_pkg::rcg_cfg_t'(rcg_pkg::CTRL_RESET[3:0]);
        else if (porSync)
            cfg_q <= rcg_pkg::rcg_cfg_t'(rcg_pkg::CTRL_RESET[3:0]); // [RULE_05] [RULE_09]
        else if (access & pwrite & pstrb[0] & (paddr == rcg_pkg::CTRL_OFFS))
        begin
            cfg_q.ratioSel   <= pwdata[rcg_pkg::CTRL_RATIO_LSB +: 2];
            cfg_q.dmaHalf    <= pwdata[rcg_pkg::CTRL_DMA_HALF];
            cfg_q.coproBlock <= pwdata[rcg_pkg::CTRL_COPRO_BLK];
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            prdata_q <= 32'h0000_0000;
        else if (setup)
        begin
            prdata_q <= 32'h0000_0000;
            if (paddr == rcg_pkg::CTRL_OFFS)
            begin
                prdata_q[rcg_pkg::CTRL_RATIO_LSB +: 2] <= cfg_q.ratioSel;
                prdata_q[rcg_pkg::CTRL_DMA_HALF]       <= cfg_q.dmaHalf;
                prdata_q[rcg_pkg::CTRL_COPRO_BLK]      <= cfg_q.coproBlock;
            end
            else if (paddr == rcg_pkg::STAT_OFFS)
            begin
                prdata_q[rcg_pkg::STAT_CPU_RST]   <= rstOut_q[0];
                prdata_q[rcg_pkg::STAT_COPRO_RST] <= rstOut_q[1];
                prdata_q[rcg_pkg::STAT_BP_RST]    <= bpRst_q;
                prdata_q[rcg_pkg::STAT_BCLK]      <= bclk_q;
                prdata_q[rcg_pkg::STAT_POR]       <= porSync;
            end
        end
    end

    // processor clock phase, restarted by power-on reset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            phase_q <= 1'b0;
        else
            phase_q <= porSync ? 1'b0 : ~phase_q; // [RULE_01] [RULE_06]
    end

    // backplane clock divider, new ratio taken only at period end
    assign bclkWrap = (bclkCnt_q == ratio_q - 4'h1);
    assign bclkRise = bclkWrap & ~porSync;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ratio_q   <= rcg_pkg::RATIO_BASE;
            bclkCnt_q <= 4'h0;
            bclk_q    <= 1'b1;
        end
        else if (porSync)
        begin
            ratio_q   <= rcg_pkg::RATIO_BASE; // [RULE_11]
            bclkCnt_q <= 4'h0;
            bclk_q    <= 1'b1;
        end
        else if (bclkWrap)
        begin
            ratio_q   <= rcg_pkg::RATIO_BASE + rcg_pkg::RATIO_STEP * {2'h0, cfg_q.ratioSel};
            bclkCnt_q <= 4'h0;
            bclk_q    <= 1'b1; // [RULE_02]
        end
        else
        begin
            bclkCnt_q <= bclkCnt_q + 4'h1;
            bclk_q    <= (bclkCnt_q + 4'h1) < (ratio_q >> 1); // [RULE_02]
        end
    end
    assign backplaneClock = bclk_q;

    // dma clock: follows backplane clock or toggles on its rising edges
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dmaDiv_q <= 1'b0;
            dma_q    <= 1'b0;
        end
        else if (porSync)
        begin
            dmaDiv_q <= 1'b0;
            dma_q    <= 1'b0;
        end
        else
        begin
            if (bclkRise)
                dmaDiv_q <= ~dmaDiv_q;
            if (cfg_q.dmaHalf)
                dma_q <= bclkRise ? ~dmaDiv_q : dmaDiv_q; // [RULE_03]
            else
                dma_q <= bclkWrap ? 1'b1 : ((bclkCnt_q + 4'h1) < (ratio_q >> 1)); // [RULE_03]
        end
    end
    assign dmaClock = dma_q;

    // timer clock: toggles every sixth reference rising edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tmrCnt_q <= 4'h0;
            tmr_q    <= 1'b0;
        end
        else if (porSync)
        begin
            tmrCnt_q <= 4'h0; // [RULE_11]
            tmr_q    <= 1'b0;
        end
        else if (refRise)
        begin
            if (tmrCnt_q == rcg_pkg::TIMER_HALF - 4'h1)
            begin
                tmrCnt_q <= 4'h0;
                tmr_q    <= ~tmr_q; // [RULE_04]
            end
            else
                tmrCnt_q <= tmrCnt_q + 4'h1;
        end
    end
    assign timerClock = tmr_q;

    // reset triggers: processor from keyboard or fast bit, coprocessor from port
    assign copTrig = ioWriteValid & (ioWriteAddr == rcg_pkg::COPRO_PORT)
                     & ~cfg_q.coproBlock; // [RULE_08] [RULE_09]
    assign trig    = {copTrig, kbdRise | fastReq}; // [RULE_07]

    // one reset pulse sequencer per processor and coprocessor
    for (genvar i = 0; i < 2; i++)
    begin : gRst
        always_comb
        begin
            st_d[i] = st_q[i];
            case (st_q[i])
                rcg_pkg::RST_IDLE:
                    if (trig[i])
                        st_d[i] = rcg_pkg::RST_HOLD;
                rcg_pkg::RST_HOLD:
                    if (holdCnt_q[i] == 16'h0000)
                        st_d[i] = rcg_pkg::RST_ALIGN;
                rcg_pkg::RST_ALIGN:
                    if (phase_q)
                        st_d[i] = rcg_pkg::RST_IDLE; // [RULE_06]
                default:
                    st_d[i] = rcg_pkg::RST_HOLD;
            endcase
            if (porSync)
                st_d[i] = rcg_pkg::RST_HOLD; // [RULE_05]
        end

        always_ff @(posedge ref_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                st_q[i]     <= rcg_pkg::RST_HOLD;
                holdCnt_q[i] <= 16'(RST_HOLD - 1);
                rstOut_q[i] <= 1'b1;
            end
            else
            begin
                st_q[i]     <= st_d[i];
                rstOut_q[i] <= (st_d[i] != rcg_pkg::RST_IDLE); // [RULE_06] [RULE_08]
                if (st_d[i] == rcg_pkg::RST_HOLD && st_q[i] != rcg_pkg::RST_HOLD)
                    holdCnt_q[i] <= 16'(RST_HOLD - 2);
                else if (porSync)
                    holdCnt_q[i] <= 16'(RST_HOLD - 1);
                else if (holdCnt_q[i] != 16'h0000)
                    holdCnt_q[i] <= holdCnt_q[i] - 16'h0001;
            end
        end
    end
    assign processorResetOut   = rstOut_q[0];
    assign coprocessorResetOut = rstOut_q[1];

    // backplane reset: set by por, released on a backplane clock rise
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            bpRst_q <= 1'b1;
        else if (porSync)
            bpRst_q <= 1'b1; // [RULE_05] [RULE_10]
        else if (bclkRise)
            bpRst_q <= 1'b0; // [RULE_10]
    end
    assign backplaneResetDrive = bpRst_q;

    // checks
    chk_bclk_high_len: assert property (@(posedge ref_clk) // [RULE_02]
        disable iff (!resetn || porSync) $rose(backplaneClock) |-> backplaneClock[*3])
        else $error("backplane clock high phase too short");
    chk_bclk_count: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_02]
        bclkCnt_q < ratio_q && ratio_q >= 4'h6 && ratio_q <= 4'hc)
        else $error("backplane divider out of range");
    chk_dma_direct: assert property (@(posedge ref_clk) // [RULE_03]
        disable iff (!resetn || porSync)
        $past(!cfg_q.dmaHalf) && $past(!porSync) |-> dmaClock == backplaneClock)
        else $error("dma clock does not follow backplane clock");
    chk_dma_half: assert property (@(posedge ref_clk) // [RULE_03]
        disable iff (!resetn || porSync)
        $past(cfg_q.dmaHalf) && $past(cfg_q.dmaHalf, 2) && $changed(dmaClock)
        |-> $rose(backplaneClock))
        else $error("halved dma clock moved off a backplane rise");
    chk_timer_edge: assert property (@(posedge ref_clk) // [RULE_04]
        disable iff (!resetn || porSync)
        $changed(timerClock) |-> $past(tmrCnt_q) == 4'h5 && $past(refRise))
        else $error("timer clock toggled off the sixth edge");
    chk_por_resets: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_05] [RULE_11]
        porSync |=> processorResetOut && coprocessorResetOut && backplaneResetDrive
                    && bclkCnt_q == 4'h0 && tmrCnt_q == 4'h0)
        else $error("power-on reset did not reset outputs and dividers");
    chk_cpu_phase: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_06]
        $fell(processorResetOut) |-> $past(phase_q))
        else $error("processor reset released on wrong phase");
    chk_cpu_hold: assert property (@(posedge ref_clk) // [RULE_06]
        disable iff (!resetn || porSync) $rose(processorResetOut) |-> processorResetOut[*8])
        else $error("processor reset pulse too short");
    chk_kbd_reset: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_07]
        (kbdRise || fastReq) && !processorResetOut |=> processorResetOut)
        else $error("keyboard or fast reset did not reset processor");
    chk_copro_port: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_08] [RULE_09]
        ioWriteValid && ioWriteAddr == rcg_pkg::COPRO_PORT && !cfg_q.coproBlock
        && !coprocessorResetOut |=> coprocessorResetOut)
        else $error("port write did not reset coprocessor");
    chk_copro_cause: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_08]
        $rose(coprocessorResetOut) |-> $past(copTrig || porSync))
        else $error("coprocessor reset without cause");
    chk_bp_release: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_10]
        $fell(backplaneResetDrive) |-> $rose(backplaneClock) && $past(!porSync))
        else $error("backplane reset released off a backplane clock rise");

    cov_kbd_reset:   cover property (@(posedge ref_clk) disable iff (!resetn)
        kbdRise ##1 processorResetOut);
    cov_copro_port:  cover property (@(posedge ref_clk) disable iff (!resetn)
        copTrig ##1 coprocessorResetOut);
    cov_dma_half:    cover property (@(posedge ref_clk) disable iff (!resetn)
        cfg_q.dmaHalf && $rose(dmaClock));
    cov_ratio_twelve: cover property (@(posedge ref_clk) disable iff (!resetn)
        ratio_q == 4'hc && $rose(backplaneClock));
endmodule

// ==== sim/rcg_far_side.sv ====
// far side model: colour burst reference, keyboard request and io writes
// assumes requests are started right after a ref_clk rising edge
`timescale 1ns/100ps
module rcg_far_side (
    input  wire logic        ref_clk,
    output logic             colorBurstReference,
    output logic             keyboardResetRequest,
    output logic             ioWriteValid,
    output logic      [15:0] ioWriteAddr
);
    // free running reference, phase unrelated to ref_clk
    initial
    begin
        keyboardResetRequest = 1'b0;
        ioWriteValid = 1'b0;
        ioWriteAddr = 16'h0000;
        colorBurstReference = 1'b0;
        #13;
        forever #143.3 colorBurstReference = ~colorBurstReference;
    end

    // keyboard request held high for a few cycles
    task automatic kbdPulse();
        keyboardResetRequest <= 1'b1;
        repeat (4) @(posedge ref_clk);
        keyboardResetRequest <= 1'b0;
    endtask

    // one-cycle io write; address goes stale afterwards
    task automatic ioWrite(input logic [15:0] a);
        ioWriteValid <= 1'b1;
        ioWriteAddr <= a;
        @(posedge ref_clk);
        ioWriteValid <= 1'b0;
        ioWriteAddr <= ~a;
    endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the reset and clock generator
// assumes a 25 MHz ref_clk, apb register access and the far side model
`timescale 1ns/100ps
module testbench;
    localparam int RH = 9;
    logic        ref_clk, resetn, psel, penable, pwrite, porIn, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        cbr, kbd, ioValid, bClk, dClk, tClk, cpuRst, copRst, bpRst;
    logic [15:0] ioAddr;
    logic [32:0] rdQ[$];
    int          cpuQ[$], copQ[$];
    int          cpuLen, copLen, errors, compares, cycles, per, hi;
    bit          porPhase, bpPrev;

    rcg_reset_clock_gen #(.RST_HOLD(RH)) dut (.ref_clk(ref_clk), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .porIn(porIn),
        .keyboardResetRequest(kbd), .colorBurstReference(cbr), .ioWriteValid(ioValid),
        .ioWriteAddr(ioAddr), .backplaneClock(bClk), .dmaClock(dClk), .timerClock(tClk),
        .processorResetOut(cpuRst), .coprocessorResetOut(copRst),
        .backplaneResetDrive(bpRst));

    rcg_far_side far (.ref_clk(ref_clk), .colorBurstReference(cbr),
        .keyboardResetRequest(kbd), .ioWriteValid(ioValid), .ioWriteAddr(ioAddr));

    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic fail(input string what);
        errors++;
        $display("unexpected at %0t: %s", $time, what);
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
        compares++;
        if (got !== exp)
            fail(what);
    endtask

    task automatic complete_run();
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; a read leaves its expected {pslverr, prdata} note
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] e);
        if (!w)
            rdQ.push_back(e);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // cycles per period and high cycles of a clock; timer counts reference rises
    task automatic measure(input int sel);
        logic p, c, r, rp;
        int   st;
        st = 0;
        per = 0;
        hi = 0;
        p = 1'b1;
        rp = 1'b1;
        for (int k = 0; k < 2000 && st < 2; k++)
        begin
            @(posedge ref_clk);
            #1;
            c = sel == 0 ? bClk : sel == 1 ? dClk : tClk;
            r = cbr;
            if (c && !p)
                st++;
            if (st == 1 && (sel < 2 || (r && !rp)))
                per++;
            if (st == 1 && sel < 2 && c)
                hi++;
            p = c;
            rp = r;
        end
    endtask

    // wait until all resets are low, then watch pulses again
    task automatic waitRelease();
        for (int k = 0; k < 200 && {cpuRst, copRst, bpRst} !== 3'b000; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check(33'({cpuRst, copRst, bpRst}), 33'h0, "resets not released");
        @(posedge ref_clk);
        #1;
        porPhase = 1'b0;
    endtask

    // read results against the oldest note
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (rdQ.size() == 0)
                fail("read without note");
            else
                check({pslverr, prdata}, rdQ.pop_front(), "read data");
        end
    end

    // reset pulse widths against the pulse notes
    always @(posedge ref_clk)
    begin
        cpuLen <= cpuRst ? cpuLen + 1 : 0;
        copLen <= copRst ? copLen + 1 : 0;
        bpPrev <= bpRst;
        if (!porPhase && cpuLen > 0 && cpuRst !== 1'b1)
        begin
            if (cpuQ.size() == 0)
                fail("stray cpu reset");
            else
                check(33'(cpuLen - cpuQ.pop_front() < 2), 33'h1, "cpu width");
            check(33'(cpuLen >= RH), 33'h1, "cpu width");
        end
        if (!porPhase && copLen > 0 && copRst !== 1'b1)
        begin
            if (copQ.size() == 0)
                fail("stray coprocessor reset");
            else
                check(33'(copLen - copQ.pop_front() < 2), 33'h1, "copro width");
            check(33'(copLen >= RH), 33'h1, "copro width");
        end
        if (!porPhase && bpRst !== 1'b0)
            fail("backplane reset outside por");
        if (bpPrev && bpRst === 1'b0)
            check(33'(bClk), 33'h1, "backplane reset phase");
    end

    // timeout
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail("timeout");
            complete_run();
        end
    end

    // main sequence
    initial
    begin
        errors = 0;
        compares = 0;
        cycles = 0;
        porPhase = 1'b1;
        {resetn, porIn, psel, penable, pwrite} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        void'($urandom(91279));
        repeat (5) @(posedge ref_clk);
        #1;
        check(33'({cpuRst, copRst, bpRst}), 33'h7, "resets in reset");
        @(posedge ref_clk);
        resetn <= 1'b1;
        waitRelease();
        @(posedge ref_clk);
        apb(rcg_pkg::CTRL_OFFS, 1'b0, 32'h0, {1'b0, rcg_pkg::CTRL_RESET});
        apb(rcg_pkg::CMD_OFFS, 1'b0, 32'h0, 33'h0);
        apb(12'h00c, 1'b0, 32'h0, 33'h1_0000_0000);
        // every ratio with the dma clock direct and halved
        for (int s = 0; s < 8; s++)
        begin
            apb(rcg_pkg::CTRL_OFFS, 1'b1, {28'($urandom()), 1'b0, 3'(s)}, 33'h0);
            apb(rcg_pkg::CTRL_OFFS, 1'b0, 32'h0, 33'(s));
            measure(0);
            measure(0);
            check(33'(per), 33'(6 + 2 * (s % 4)), "backplane period");
            check(33'(hi), 33'(3 + (s % 4)), "backplane duty");
            measure(1);
            check(33'(per), 33'((6 + 2 * (s % 4)) * (s / 4 + 1)), "dma period");
        end
        measure(2);
        check(33'(per), 33'd12, "timer divide");
        // fast reset, with a second request while the pulse stands
        cpuQ.push_back(RH);
        apb(rcg_pkg::CMD_OFFS, 1'b1, {28'($urandom()), 4'h1}, 33'h0);
        apb(rcg_pkg::CMD_OFFS, 1'b1, 32'h1, 33'h0);
        repeat (RH + 4) @(posedge ref_clk);
        cpuQ.push_back(RH);
        far.kbdPulse();
        repeat (RH + 4) @(posedge ref_clk);
        // coprocessor port, another port, then the port blocked
        copQ.push_back(RH);
        far.ioWrite(rcg_pkg::COPRO_PORT);
        repeat (RH + 4) @(posedge ref_clk);
        far.ioWrite(16'($urandom()) | 16'h0100);
        apb(rcg_pkg::CTRL_OFFS, 1'b1, 32'h8, 33'h0);
        far.ioWrite(rcg_pkg::COPRO_PORT);
        repeat (RH + 4) @(posedge ref_clk);
        check(33'(cpuQ.size() + copQ.size()), 33'h0, "missing reset pulse");
        // hard reset in mid-run clears settings and restarts dividers
        apb(rcg_pkg::CTRL_OFFS, 1'b1, 32'hb, 33'h0);
        porPhase = 1'b1;
        porIn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check(33'({cpuRst, copRst, bpRst}), 33'h7, "por resets");
        @(posedge ref_clk);
        porIn <= 1'b0;
        waitRelease();
        apb(rcg_pkg::CTRL_OFFS, 1'b0, 32'h0, 33'h0);
        measure(0);
        check(33'(per), 33'd6, "default ratio after por");
        complete_run();
    end
endmodule
